// *** rtl/dcf_pkg.sv ***
// Purpose: shared constants for the deep nine-bit buffer with status flags
// Assumes: one system clock; port clocks arrive as pins and are sampled
// Notes: flag offsets are loaded nine bits at a time
package dcf_pkg;
  // ****************************************
  // data shape and depth
  // ****************************************
  localparam int DATA_W = 9;
  localparam int DEPTH = 16384;
  // ****************************************
  // reset values of the flag offsets
  // ****************************************
  localparam int AE_OFFSET_RST = 7;
  localparam int AF_OFFSET_RST = 7;
  // ****************************************
  // offset load sequence positions
  // ****************************************
  localparam logic [1:0] LD_AE_LO = 2'h0;
  localparam logic [1:0] LD_AE_HI = 2'h1;
  localparam logic [1:0] LD_AF_LO = 2'h2;
  localparam logic [1:0] LD_AF_HI = 2'h3;
  // synchroniser depth before logic reads a pin
  localparam int SYNC_STAGES = 2;
endpackage

// *** rtl/dcf_fifo.sv ***
// Purpose: flip-flop storage queue with valid and ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: count output lets the owner derive its own flags
`timescale 1ns/100ps
`default_nettype none
module dcf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [CW-1:0] cnt;
  } dcf_fifo_state_t;

  dcf_fifo_state_t st_reg;
  dcf_fifo_state_t st_next;
  logic push;
  logic pop;

  // honest flags straight from the level
  assign in_ready = (st_reg.cnt != CW'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data = st_reg.mem[st_reg.rd_idx];
  assign count = st_reg.cnt;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointer wrap is explicit so depth need not be a power of two
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_idx] = in_data;
      st_next.wr_idx = (st_reg.wr_idx == AW'(DEPTH-1)) ? '0 : st_reg.wr_idx + 1'b1;
    end
    if (pop) begin
      st_next.rd_idx = (st_reg.rd_idx == AW'(DEPTH-1)) ? '0 : st_reg.rd_idx + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  // storage itself is not cleared, only pointers and level
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg.wr_idx <= '0;
      st_reg.rd_idx <= '0;
      st_reg.cnt <= '0;
      st_reg.mem <= st_next.mem;
    end else begin
      st_reg <= st_next;
    end
  end

  fifo_bound_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_reg.cnt <= CW'(DEPTH)) else $error("fill level above depth");
endmodule
`default_nettype wire

// *** rtl/dcf_top.sv ***
// Purpose: buffer with pin-style write and read ports and active-low flags
// Assumes: port clocks are much slower than clk_sys and are sampled
// Notes: the two read enables are ORed before sampling; every other pin passes two flip-flops before any logic reads it
`timescale 1ns/100ps
`default_nettype none
module dcf_top #(
  parameter int DATA_W = dcf_pkg::DATA_W,
  parameter int DEPTH = dcf_pkg::DEPTH
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // device reset pin
  input wire logic reset_n,
  // write port pins
  input wire logic write_clk,
  input wire logic write_enable_first_n,
  input wire logic write_enable_second_or_load,
  input wire logic [DATA_W-1:0] data_in,
  // read port pins
  input wire logic read_clk,
  input wire logic read_enable_first_n,
  input wire logic read_enable_second_n,
  input wire logic output_enable_n,
  output logic [DATA_W-1:0] data_out,
  output logic data_out_oe_n,
  // status flags
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n
);
  localparam int CW = $clog2(DEPTH+1);
  localparam int OW = 2 * DATA_W;
  localparam int NPIN = 7 + DATA_W;

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic wclk_s3;
    logic rclk_s3;
    logic mode_load;
    logic [1:0] ld_idx;
    logic [OW-1:0] ae_off;
    logic [OW-1:0] af_off;
    logic ef_n;
    logic ff_n;
    logic pae_n;
    logic paf_n;
    logic [DATA_W-1:0] q;
  } dcf_top_state_t;

  dcf_top_state_t st_reg;
  dcf_top_state_t st_next;
  logic [NPIN-1:0] pins;
  logic rst;
  logic wclk_rise;
  logic rclk_rise;
  logic write_enable_first_n_n;
  logic wen2;
  logic ren_n;
  logic [DATA_W-1:0] d_s;
  logic wr_req;
  logic ld_req;
  logic rd_req;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic [CW-1:0] level;

  // ****************************************
  // pin sampling
  // ****************************************
  assign pins = {reset_n, write_clk, read_clk, write_enable_first_n, write_enable_second_or_load,
                 read_enable_first_n | read_enable_second_n, output_enable_n, data_in};
  assign rst = sys_rst | ~st_reg.s2[NPIN-1];
  assign wclk_rise = st_reg.s2[NPIN-2] & ~st_reg.wclk_s3;
  assign rclk_rise = st_reg.s2[NPIN-3] & ~st_reg.rclk_s3;
  assign write_enable_first_n_n = st_reg.s2[NPIN-4];
  assign wen2 = st_reg.s2[NPIN-5];
  assign ren_n = st_reg.s2[NPIN-6];
  assign d_s = st_reg.s2[DATA_W-1:0];

  // ****************************************
  // request decode
  // ****************************************
  // each pin clock is its own edge, so the ports run independently
  assign wr_req = wclk_rise & ~write_enable_first_n_n & wen2 & st_reg.ff_n;
  assign ld_req = wclk_rise & ~write_enable_first_n_n & ~wen2 & st_reg.mode_load;
  assign rd_req = rclk_rise & ~ren_n & st_reg.ef_n;

  // storage, one nine-bit word per entry
  dcf_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) u_store (
    .clk_sys(clk_sys),
    .sys_rst(rst),
    .in_valid(wr_req),
    .in_ready(fifo_in_ready),
    .in_data(d_s),
    .out_valid(fifo_out_valid),
    .out_ready(rd_req),
    .out_data(fifo_out_data),
    .count(level)
  );

  // ****************************************
  // state update
  // ****************************************
  // flags lag the level by up to one port clock; that is the price of edge-only updates
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    st_next.wclk_s3 = st_reg.s2[NPIN-2];
    st_next.rclk_s3 = st_reg.s2[NPIN-3];
    if (rst) begin
      // second enable low at reset selects load mode
      st_next.mode_load = ~wen2;
      st_next.ld_idx = dcf_pkg::LD_AE_LO;
      st_next.ae_off = OW'(dcf_pkg::AE_OFFSET_RST);
      st_next.af_off = OW'(dcf_pkg::AF_OFFSET_RST);
      st_next.ef_n = 1'b0;
      st_next.ff_n = 1'b1;
      st_next.pae_n = 1'b0;
      st_next.paf_n = 1'b1;
      st_next.q = '0;
    end else begin
      if (ld_req) begin
        // offsets fill low half then high half, empty side first
        case (st_reg.ld_idx)
          dcf_pkg::LD_AE_LO: st_next.ae_off[DATA_W-1:0] = d_s;
          dcf_pkg::LD_AE_HI: st_next.ae_off[OW-1:DATA_W] = d_s;
          dcf_pkg::LD_AF_LO: st_next.af_off[DATA_W-1:0] = d_s;
          dcf_pkg::LD_AF_HI: st_next.af_off[OW-1:DATA_W] = d_s;
          default: st_next.ae_off = st_reg.ae_off;
        endcase
        st_next.ld_idx = st_reg.ld_idx + 2'h1;
      end
      // empty side flags move only on read clock edges
      if (rclk_rise) begin
        st_next.ef_n = (level != '0);
        st_next.pae_n = (OW'(level) > st_reg.ae_off);
      end
      // full side flags move only on write clock edges
      if (wclk_rise) begin
        st_next.ff_n = (level != CW'(DEPTH)) & fifo_in_ready;
        st_next.paf_n = (OW'(level) + st_reg.af_off < OW'(DEPTH));
      end
      if (rd_req && fifo_out_valid) begin
        st_next.q = fifo_out_data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    st_reg <= st_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  // expansion logic may hold either enable of a port; both are honoured alike, except a low second write enable in load mode loads offsets
  assign data_out = st_reg.q;
  assign data_out_oe_n = st_reg.s2[DATA_W];
  assign empty_flag_n = st_reg.ef_n;
  assign full_flag_n = st_reg.ff_n;
  assign almost_empty_flag_n = st_reg.pae_n;
  assign almost_full_flag_n = st_reg.paf_n;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence wr_edge_s;
    wclk_rise && !write_enable_first_n_n && wen2 && full_flag_n;
  endsequence

  write_store_a: assert property (wr_edge_s ##0 (level < CW'(DEPTH)) |=> level == $past(level) + CW'(1)
    || rd_req || $past(rd_req)) else $error("accepted write did not raise level");
  full_block_a: assert property (!full_flag_n && !rd_req |=> level == $past(level))
    else $error("level moved while full");
  empty_block_a: assert property (!empty_flag_n |-> !rd_req) else $error("read taken while empty");
  empty_edge_a: assert property (!$stable(empty_flag_n) || !$stable(almost_empty_flag_n) |-> $past(rclk_rise))
    else $error("empty flags moved off a read edge");
  full_edge_a: assert property (!$stable(full_flag_n) || !$stable(almost_full_flag_n) |-> $past(wclk_rise))
    else $error("full flags moved off a write edge");
  flag_hold_a: assert property ($changed(empty_flag_n) |=> $stable(empty_flag_n)) else $error("flag glitched");
  read_data_a: assert property (rd_req |=> data_out == $past(fifo_out_data)) else $error("read data wrong");
  // enable reaches the output two system clocks after the pin, through the synchroniser
  oe_follow_a: assert property (data_out_oe_n == $past(output_enable_n, 2))
    else $error("output enable wrong");
  reset_off_a: assert property (@(posedge clk_sys) disable iff (1'b0)
    sys_rst |=> st_reg.ae_off == OW'(dcf_pkg::AE_OFFSET_RST)
    && st_reg.af_off == OW'(dcf_pkg::AF_OFFSET_RST) && !empty_flag_n) else $error("reset defaults wrong");
endmodule
`default_nettype wire

// *** test/dcf_port_model.sv ***
// Purpose: writing and reading logic on the far side of the buffer pins
// Assumes: each pin clock phase lasts three clk_sys cycles
// Notes: enables are held between pulses; an idle pulse releases them
`timescale 1ns/100ps
`default_nettype none
module dcf_port_model (
  // system clock
  input wire logic clk_sys,
  // write port pins
  output logic write_clk,
  output logic write_enable_first_n,
  output logic write_enable_second_or_load,
  output logic [8:0] data_in,
  // read port pins
  output logic read_clk,
  output logic read_enable_first_n,
  output logic read_enable_second_n
);
  // ************
  // idle pins
  // ************
  // second enable high at reset keeps the pin a plain write enable
  initial begin
    write_clk = 1'b0;
    write_enable_first_n = 1'b1;
    write_enable_second_or_load = 1'b1;
    data_in = 9'h000;
    read_clk = 1'b0;
    read_enable_first_n = 1'b1;
    read_enable_second_n = 1'b1;
  end
  // step just past a clk_sys edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // one write clock period; en low gives an edge that only updates flags
  task automatic wr(input logic [8:0] d, input logic en);
    data_in = d;
    write_enable_first_n = ~en;
    tick(3);
    write_clk = 1'b1;
    tick(3);
    write_clk = 1'b0;
  endtask
  // second write enable level; low across a reset selects load mode
  task automatic set_second(input logic v);
    write_enable_second_or_load = v;
  endtask
  // one offset word loaded through the load strobe
  task automatic load(input logic [8:0] d);
    data_in = d;
    write_enable_first_n = 1'b0;
    write_enable_second_or_load = 1'b0;
    tick(3);
    write_clk = 1'b1;
    tick(3);
    write_clk = 1'b0;
  endtask
  // one read clock period with only the first enable asserted: no read
  task automatic rd_one();
    read_enable_first_n = 1'b0;
    read_enable_second_n = 1'b1;
    tick(3);
    read_clk = 1'b1;
    tick(3);
    read_clk = 1'b0;
  endtask
  // one read clock period; both enables follow en
  task automatic rd(input logic en);
    read_enable_first_n = ~en;
    read_enable_second_n = ~en;
    tick(3);
    read_clk = 1'b1;
    tick(3);
    read_clk = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Purpose: pin-level bench for the buffer, sixteen words deep
// Assumes: far-side model drives the port pins
// Notes: every burst ends with an idle edge, since flags lag the data
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys, sys_rst, reset_n, output_enable_n;
  logic write_clk, write_enable_first_n, write_enable_second_or_load;
  logic read_clk, read_enable_first_n, read_enable_second_n;
  logic [8:0] data_in, data_out;
  logic data_out_oe_n, empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
  int num_errors = 0;
  int checks = 0;
  int k = 0;
  logic [8:0] exp_q[$];
  logic [8:0] last_rd = 9'h000;
  // ************
  // clock and parts
  // ************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  dcf_port_model p_model (.clk_sys(clk_sys), .write_clk(write_clk), .write_enable_first_n(write_enable_first_n),
    .write_enable_second_or_load(write_enable_second_or_load), .data_in(data_in), .read_clk(read_clk),
    .read_enable_first_n(read_enable_first_n), .read_enable_second_n(read_enable_second_n));
  // small depth keeps fill and drain short
  dcf_top #(.DEPTH(16)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reset_n(reset_n), .write_clk(write_clk),
    .write_enable_first_n(write_enable_first_n), .write_enable_second_or_load(write_enable_second_or_load),
    .data_in(data_in), .read_clk(read_clk), .read_enable_first_n(read_enable_first_n),
    .read_enable_second_n(read_enable_second_n), .output_enable_n(output_enable_n), .data_out(data_out),
    .data_out_oe_n(data_out_oe_n), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n));
  // ************
  // helpers
  // ************
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic flags(input logic e, input logic ae, input logic af, input logic f);
    chk("empty_flag_n", 9'(e), 9'(empty_flag_n));
    chk("almost_empty_flag_n", 9'(ae), 9'(almost_empty_flag_n));
    chk("almost_full_flag_n", 9'(af), 9'(almost_full_flag_n));
    chk("full_flag_n", 9'(f), 9'(full_flag_n));
  endtask
  // n words back to back, then an idle write edge
  task automatic put(input int n);
    logic [8:0] d;
    d = 9'h000;
    repeat (n) begin
      d = 9'(k * 37) + 9'h011;
      k++;
      exp_q.push_back(d);
      p_model.wr(d, 1'b1);
    end
    p_model.wr(~d, 1'b0);
  endtask
  // n reads compared in order, then an idle read edge
  task automatic get(input int n);
    repeat (n) begin
      p_model.rd(1'b1);
      last_rd = exp_q.pop_front();
      chk("data_out", last_rd, data_out);
    end
    p_model.rd(1'b0);
  endtask
  task automatic wrap_up();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ************
  // watchdog
  // ************
  initial begin
    #200000;
    num_errors++;
    $display("watchdog expired");
    wrap_up();
  end
  // ************
  // tests
  // ************
  initial begin
    sys_rst = 1'b1;
    reset_n = 1'b1;
    output_enable_n = 1'b0;
    p_model.tick(4);
    sys_rst = 1'b0;
    p_model.tick(1);
    flags(1'b0, 1'b0, 1'b1, 1'b1);
    chk("data_out", 9'h000, data_out);
    put(8);
    flags(1'b0, 1'b0, 1'b1, 1'b1);
    put(1);
    chk("almost_full_flag_n", 9'h000, 9'(almost_full_flag_n));
    put(7);
    chk("full_flag_n", 9'h000, 9'(full_flag_n));
    p_model.wr(9'h1AA, 1'b1);
    p_model.wr(9'h055, 1'b0);
    chk("full_flag_n", 9'h000, 9'(full_flag_n));
    p_model.rd(1'b0);
    flags(1'b1, 1'b1, 1'b0, 1'b0);
    get(8);
    chk("almost_empty_flag_n", 9'h001, 9'(almost_empty_flag_n));
    get(1);
    chk("almost_empty_flag_n", 9'h000, 9'(almost_empty_flag_n));
    get(7);
    flags(1'b0, 1'b0, 1'b0, 1'b0);
    p_model.rd(1'b1);
    chk("data_out", last_rd, data_out);
    p_model.wr(9'h1FF, 1'b0);
    flags(1'b0, 1'b0, 1'b1, 1'b1);
    output_enable_n = 1'b1;
    p_model.tick(3);
    chk("data_out_oe_n", 9'h001, 9'(data_out_oe_n));
    output_enable_n = 1'b0;
    p_model.tick(3);
    chk("data_out_oe_n", 9'h000, 9'(data_out_oe_n));
    // writes and reads overlap with write and read pulses in step, both clocks rising together
    put(3);
    chk("empty_flag_n", 9'h000, 9'(empty_flag_n));
    p_model.rd(1'b0);
    fork
      put(3);
      get(3);
    join
    get(3);
    chk("empty_flag_n", 9'h000, 9'(empty_flag_n));
    put(2);
    reset_n = 1'b0;
    p_model.tick(4);
    reset_n = 1'b1;
    p_model.tick(4);
    exp_q.delete();
    flags(1'b0, 1'b0, 1'b1, 1'b1);
    chk("data_out", 9'h000, data_out);
    put(1);
    p_model.rd(1'b0);
    get(1);
    // load mode: offsets 2 above empty and 3 below full
    p_model.set_second(1'b0);
    reset_n = 1'b0;
    p_model.tick(4);
    reset_n = 1'b1;
    p_model.tick(4);
    p_model.load(9'h002);
    p_model.load(9'h000);
    p_model.load(9'h003);
    p_model.load(9'h000);
    p_model.set_second(1'b1);
    put(3);
    p_model.rd(1'b0);
    flags(1'b1, 1'b1, 1'b1, 1'b1);
    p_model.rd_one();
    chk("data_out", 9'h000, data_out);
    put(10);
    chk("almost_full_flag_n", 9'h000, 9'(almost_full_flag_n));
    get(13);
    flags(1'b0, 1'b0, 1'b0, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
